// File: shared/dvm_pkg.sv
package dvm_pkg;

  // clock and measurement timing
  localparam longint unsigned CLK_HZ      = 100_000_000;
  localparam longint unsigned MS_PER_S    = 1000;
  localparam longint unsigned GATE_MS     = 100;
  localparam longint unsigned DEV_SLOW_MS = 60000;
  localparam longint unsigned DEV_FAST_MS = 20000;
  localparam longint unsigned DIR_MS      = 400;
  localparam longint unsigned GATE_CYC     = GATE_MS * CLK_HZ / MS_PER_S;
  localparam longint unsigned DEV_SLOW_CYC = DEV_SLOW_MS * CLK_HZ / MS_PER_S;
  localparam longint unsigned DEV_FAST_CYC = DEV_FAST_MS * CLK_HZ / MS_PER_S;
  localparam longint unsigned DIR_CYC      = DIR_MS * CLK_HZ / MS_PER_S;
  localparam longint unsigned GATE_PER_S   = MS_PER_S / GATE_MS;

  // widths
  localparam int TMR_W = 36;
  localparam int VEL_W = 16;
  localparam int PPC_W = 16;
  localparam int TOL_W = 6;
  localparam int CMP_W = 24;

  // velocity bands and tolerance limits
  localparam logic [CMP_W-1:0] SPEED_LOW_CMS  = 24'h00000a;
  localparam logic [CMP_W-1:0] SPEED_HIGH_CMS = 24'h00001e;
  localparam logic [CMP_W-1:0] GATE_RATE      = CMP_W'(GATE_PER_S);
  localparam logic [TOL_W-1:0] TOL_MAX_PCT    = 6'h2d;
  localparam logic [CMP_W-1:0] PCT_FULL       = 24'h000064;
  localparam logic signed [VEL_W-1:0] VEL_MAX = 16'sh7fff;
  localparam logic signed [VEL_W-1:0] VEL_MIN = -16'sh7fff;

  typedef struct packed {
    logic ch1;
    logic ch2;
  } dvm_enc_t;

  typedef struct packed {
    logic             velEnable;
    logic [PPC_W-1:0] pulsesPerCm;
    logic [TOL_W-1:0] tolPct;
  } dvm_cfg_t;

  typedef enum logic [1:0] {
    BAND_STILL = 2'b00,
    BAND_SLOW  = 2'b01,
    BAND_FAST  = 2'b11
  } dvm_band_t;

  typedef enum logic [0:0] {
    ST_RUN  = 1'b0,
    ST_LOCK = 1'b1
  } dvm_state_t;

  typedef struct packed {
    logic                    lockOut;
    logic                    devLock;
    logic                    dirLock;
    logic                    devActive;
    logic                    dirActive;
    dvm_band_t               band;
    logic signed [VEL_W-1:0] vehVel;
    logic signed [VEL_W-1:0] velA;
    logic signed [VEL_W-1:0] velB;
    logic                    valid;
  } dvm_stat_t;

endpackage

// File: hdl/dvm_velocity_monitor.sv
// Behaviour
// - two dual-channel encoder inputs yield velocity usable for case selection
// - encoder inputs evaluated only while velocity option is enabled
// - pulse counts scaled to velocity by configured pulses per centimetre
// - deviation tolerance configurable in percent, at most forty-five
// - larger magnitude velocity is reference and vehicle velocity
// - deviation beyond tolerance longer than allowed time forces lock-out
// - below ten cm/s deviation never causes shutdown
// - between ten and thirty cm/s deviation tolerated sixty seconds
// - at thirty cm/s or more deviation tolerated twenty seconds
// - at ten cm/s or more opposite directions tolerated 0.4 seconds
`timescale 1ns/1ps

module dvm_velocity_monitor #(
  parameter logic [dvm_pkg::TMR_W-1:0] P_GATE_CYC =
    dvm_pkg::TMR_W'(dvm_pkg::GATE_CYC),
  parameter logic [dvm_pkg::TMR_W-1:0] P_DEV_SLOW_CYC =
    dvm_pkg::TMR_W'(dvm_pkg::DEV_SLOW_CYC),
  parameter logic [dvm_pkg::TMR_W-1:0] P_DEV_FAST_CYC =
    dvm_pkg::TMR_W'(dvm_pkg::DEV_FAST_CYC),
  parameter logic [dvm_pkg::TMR_W-1:0] P_DIR_CYC =
    dvm_pkg::TMR_W'(dvm_pkg::DIR_CYC)
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // encoder pins
  input  wire dvm_pkg::dvm_enc_t encA,
  input  wire dvm_pkg::dvm_enc_t encB,
  // configuration
  input  wire dvm_pkg::dvm_cfg_t cfg,
  // status
  output dvm_pkg::dvm_stat_t     status
);

  localparam int VW = dvm_pkg::VEL_W;
  localparam int CW = dvm_pkg::CMP_W;
  localparam int TW = dvm_pkg::TMR_W;

  function automatic logic signed [1:0] quadStep(
    input dvm_pkg::dvm_enc_t cur,
    input dvm_pkg::dvm_enc_t prev
  );
    logic signed [1:0] s;
    s = 2'sh0;
    if (cur.ch1 && !prev.ch1) begin
      s = cur.ch2 ? -2'sh1 : 2'sh1;
    end
    return s;
  endfunction

  function automatic logic signed [VW-1:0] satAdd(
    input logic signed [VW-1:0] acc,
    input logic signed [1:0]    step
  );
    logic signed [VW:0] sum;
    sum = {acc[VW-1], acc} + (VW+1)'(step);
    if (sum > (VW+1)'(dvm_pkg::VEL_MAX)) begin
      return dvm_pkg::VEL_MAX;
    end
    if (sum < (VW+1)'(dvm_pkg::VEL_MIN)) begin
      return dvm_pkg::VEL_MIN;
    end
    return sum[VW-1:0];
  endfunction

  function automatic logic [VW-1:0] magOf(input logic signed [VW-1:0] v);
    return v[VW-1] ? VW'(-v) : VW'(v);
  endfunction

  // product kept at comparison width
  function automatic logic [CW-1:0] scaleCms(
    input logic [CW-1:0] a,
    input logic [CW-1:0] b
  );
    return a * b;
  endfunction

  // band from scaled speed and band limits
  function automatic dvm_pkg::dvm_band_t bandOf(
    input logic [CW-1:0] speed,
    input logic [CW-1:0] low,
    input logic [CW-1:0] high
  );
    dvm_pkg::dvm_band_t b;
    b = dvm_pkg::BAND_STILL;
    if (speed >= high) begin
      b = dvm_pkg::BAND_FAST;
    end else if (speed >= low) begin
      b = dvm_pkg::BAND_SLOW;
    end
    return b;
  endfunction

  // deviation over tolerance, no division
  function automatic logic overTol(
    input logic [VW-1:0]             diff,
    input logic [VW-1:0]             refMag,
    input logic [dvm_pkg::TOL_W-1:0] tol
  );
    return scaleCms(CW'(diff), dvm_pkg::PCT_FULL) >
           scaleCms(CW'(tol), CW'(refMag));
  endfunction

  // violation timer, restarts when condition clears
  function automatic logic [TW-1:0] tmrStep(
    input logic          cond,
    input logic [TW-1:0] tmr
  );
    return cond ? tmr + TW'(1) : '0;
  endfunction

  // pin synchronisers
  dvm_pkg::dvm_enc_t syncA1_ff, syncA2_ff, prevA_ff;
  dvm_pkg::dvm_enc_t syncB1_ff, syncB2_ff, prevB_ff;
  dvm_pkg::dvm_enc_t nxt_syncA1, nxt_syncA2, nxt_prevA;
  dvm_pkg::dvm_enc_t nxt_syncB1, nxt_syncB2, nxt_prevB;

  always_comb begin
    nxt_syncA1 = encA;
    nxt_syncA2 = syncA1_ff;
    nxt_prevA  = syncA2_ff;
    nxt_syncB1 = encB;
    nxt_syncB2 = syncB1_ff;
    nxt_prevB  = syncB2_ff;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      syncA1_ff <= '0;
      syncA2_ff <= '0;
      prevA_ff  <= '0;
      syncB1_ff <= '0;
      syncB2_ff <= '0;
      prevB_ff  <= '0;
    end else begin
      syncA1_ff <= nxt_syncA1;
      syncA2_ff <= nxt_syncA2;
      prevA_ff  <= nxt_prevA;
      syncB1_ff <= nxt_syncB1;
      syncB2_ff <= nxt_syncB2;
      prevB_ff  <= nxt_prevB;
    end
  end

  // pulse counting over a gate window
  logic [TW-1:0]          gateCnt_ff, nxt_gateCnt;
  logic signed [VW-1:0]   accA_ff, accB_ff, nxt_accA, nxt_accB;
  logic signed [VW-1:0]   velA_ff, velB_ff, nxt_velA, nxt_velB;
  logic                   valid_ff, nxt_valid;
  logic                   gateTick;

  always_comb begin
    gateTick    = (gateCnt_ff == P_GATE_CYC - TW'(1));
    nxt_gateCnt = gateTick ? '0 : gateCnt_ff + TW'(1);
    nxt_accA    = satAdd(accA_ff, quadStep(syncA2_ff, prevA_ff));
    nxt_accB    = satAdd(accB_ff, quadStep(syncB2_ff, prevB_ff));
    nxt_velA    = velA_ff;
    nxt_velB    = velB_ff;
    nxt_valid   = valid_ff;
    if (gateTick) begin
      nxt_velA  = nxt_accA;
      nxt_velB  = nxt_accB;
      nxt_accA  = '0;
      nxt_accB  = '0;
      nxt_valid = 1'b1;
    end
    if (!cfg.velEnable) begin
      nxt_gateCnt = '0;
      nxt_accA    = '0;
      nxt_accB    = '0;
      nxt_velA    = '0;
      nxt_velB    = '0;
      nxt_valid   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gateCnt_ff <= '0;
      accA_ff    <= '0;
      accB_ff    <= '0;
      velA_ff    <= '0;
      velB_ff    <= '0;
      valid_ff   <= 1'b0;
    end else begin
      gateCnt_ff <= nxt_gateCnt;
      accA_ff    <= nxt_accA;
      accB_ff    <= nxt_accB;
      velA_ff    <= nxt_velA;
      velB_ff    <= nxt_velB;
      valid_ff   <= nxt_valid;
    end
  end

  // velocity evaluation
  logic [VW-1:0]          magA, magB, magRef, magDiff;
  logic                   aLarger;
  logic signed [VW-1:0]   vehVel;
  logic [dvm_pkg::TOL_W-1:0] tolEff;
  logic [CW-1:0]          speedScaled, lowLimit, highLimit;
  dvm_pkg::dvm_band_t     band;
  logic                   devCond, dirCond;

  always_comb begin
    magA    = magOf(velA_ff);
    magB    = magOf(velB_ff);
    aLarger = (magA >= magB);
    magRef  = aLarger ? magA : magB;
    vehVel  = aLarger ? velA_ff : velB_ff;
    magDiff = aLarger ? magA - magB : magB - magA;
    tolEff = (cfg.tolPct > dvm_pkg::TOL_MAX_PCT) ?
             dvm_pkg::TOL_MAX_PCT : cfg.tolPct;
    // cm/s = pulses per gate * gate rate / pulses per cm
    speedScaled = scaleCms(CW'(magRef), dvm_pkg::GATE_RATE);
    lowLimit  = scaleCms(dvm_pkg::SPEED_LOW_CMS, CW'(cfg.pulsesPerCm));
    highLimit = scaleCms(dvm_pkg::SPEED_HIGH_CMS, CW'(cfg.pulsesPerCm));
    band = bandOf(speedScaled, lowLimit, highLimit);
    devCond = valid_ff && overTol(magDiff, magRef, tolEff)
              && (band != dvm_pkg::BAND_STILL);
    dirCond = valid_ff && (velA_ff != '0) && (velB_ff != '0)
              && (velA_ff[VW-1] != velB_ff[VW-1])
              && (band != dvm_pkg::BAND_STILL);
  end

  // violation timers and lock-out
  logic [TW-1:0]       devTmr_ff, dirTmr_ff, nxt_devTmr, nxt_dirTmr;
  logic [TW-1:0]       devLimit;
  dvm_pkg::dvm_state_t state_ff, nxt_state;
  logic                devLock_ff, dirLock_ff, nxt_devLock, nxt_dirLock;
  logic                devExpire, dirExpire;

  always_comb begin
    devLimit = (band == dvm_pkg::BAND_FAST) ?
               P_DEV_FAST_CYC : P_DEV_SLOW_CYC;
    nxt_devTmr = tmrStep(devCond, devTmr_ff);
    nxt_dirTmr = tmrStep(dirCond, dirTmr_ff);
    devExpire  = devCond && (nxt_devTmr > devLimit);
    dirExpire  = dirCond && (nxt_dirTmr > P_DIR_CYC);
    nxt_state   = state_ff;
    nxt_devLock = devLock_ff;
    nxt_dirLock = dirLock_ff;
    unique case (state_ff)
      dvm_pkg::ST_RUN: begin
        if (devExpire || dirExpire) begin
          nxt_state   = dvm_pkg::ST_LOCK;
          nxt_devLock = devExpire;
          nxt_dirLock = dirExpire;
        end
      end
      dvm_pkg::ST_LOCK: begin
        nxt_state = dvm_pkg::ST_LOCK;
      end
    endcase
    if (state_ff == dvm_pkg::ST_LOCK) begin
      nxt_devTmr = devTmr_ff;
      nxt_dirTmr = dirTmr_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      devTmr_ff  <= '0;
      dirTmr_ff  <= '0;
      state_ff   <= dvm_pkg::ST_RUN;
      devLock_ff <= 1'b0;
      dirLock_ff <= 1'b0;
    end else begin
      devTmr_ff  <= nxt_devTmr;
      dirTmr_ff  <= nxt_dirTmr;
      state_ff   <= nxt_state;
      devLock_ff <= nxt_devLock;
      dirLock_ff <= nxt_dirLock;
    end
  end

  // registered status
  dvm_pkg::dvm_stat_t stat_ff, nxt_stat;

  always_comb begin
    nxt_stat.lockOut   = (nxt_state == dvm_pkg::ST_LOCK);
    nxt_stat.devLock   = nxt_devLock;
    nxt_stat.dirLock   = nxt_dirLock;
    nxt_stat.devActive = devCond;
    nxt_stat.dirActive = dirCond;
    nxt_stat.band      = band;
    nxt_stat.vehVel    = vehVel;
    nxt_stat.velA      = velA_ff;
    nxt_stat.velB      = velB_ff;
    nxt_stat.valid     = valid_ff;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign status = stat_ff;

endmodule // dvm_velocity_monitor

// File: bench/dvm_velocity_monitor_assertions.sv
`timescale 1ns/1ps
module dvm_velocity_monitor_assertions #(
  parameter logic [dvm_pkg::TMR_W-1:0] P_GATE_CYC     = 36'h64,
  parameter logic [dvm_pkg::TMR_W-1:0] P_DEV_SLOW_CYC = 36'h7d0,
  parameter logic [dvm_pkg::TMR_W-1:0] P_DEV_FAST_CYC = 36'h258,
  parameter logic [dvm_pkg::TMR_W-1:0] P_DIR_CYC      = 36'h32
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               arst_n,
  // watched ports
  input wire dvm_pkg::dvm_enc_t  encA,
  input wire dvm_pkg::dvm_enc_t  encB,
  input wire dvm_pkg::dvm_cfg_t  cfg,
  input wire dvm_pkg::dvm_stat_t status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [dvm_pkg::TMR_W-1:0] devRun_ff;
  logic [dvm_pkg::TMR_W-1:0] dirRun_ff;
  logic [15:0]               magA;
  logic [15:0]               magB;
  logic [15:0]               magV;
  logic [17:0]               ppc;
  // consecutive active cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      devRun_ff <= '0;
      dirRun_ff <= '0;
    end else begin
      devRun_ff <= status.devActive ? devRun_ff + 36'h1 : '0;
      dirRun_ff <= status.dirActive ? dirRun_ff + 36'h1 : '0;
    end
  end
  always_comb begin
    magA = status.velA[15] ? 16'(-status.velA) : status.velA;
    magB = status.velB[15] ? 16'(-status.velB) : status.velB;
    magV = status.vehVel[15] ? 16'(-status.vehVel) : status.vehVel;
    ppc  = 18'(cfg.pulsesPerCm);
  end
  sequence s_off;
    !cfg.velEnable [*2];
  endsequence
  sequence s_fastDev;
    (status.band == dvm_pkg::BAND_FAST &&
     devRun_ff > P_DEV_FAST_CYC + 36'h4) [*3];
  endsequence
  a_lock_sticky: assert property (status.lockOut |=> status.lockOut)
    else $error("lock-out dropped");
  a_lock_cause: assert property ($rose(status.lockOut) |->
    status.devLock || status.dirLock) else $error("lock without cause");
  a_still_quiet: assert property (status.band == dvm_pkg::BAND_STILL |->
    !status.devActive && !status.dirActive) else $error("still active");
  a_off_zero: assert property (s_off |-> status.velA == 16'h0 &&
    status.velB == 16'h0 && !status.valid) else $error("disabled moving");
  a_veh_max: assert property (status.valid |->
    magV == (magA > magB ? magA : magB)) else $error("vehicle speed");
  a_band_map: assert property (status.valid |-> status.band ==
    ({2'h0, magV} < ppc ? dvm_pkg::BAND_STILL :
     {2'h0, magV} < ppc * 18'h3 ? dvm_pkg::BAND_SLOW : dvm_pkg::BAND_FAST))
    else $error("band mismatch");
  a_dir_early: assert property ($rose(status.dirLock) |->
    dirRun_ff >= P_DIR_CYC - 36'h2) else $error("direction lock early");
  a_dir_late: assert property (dirRun_ff > P_DIR_CYC + 36'h4 |->
    status.dirLock) else $error("direction lock late");
  a_dev_late: assert property (s_fastDev |-> status.devLock)
    else $error("fast deviation lock late");
  a_dev_early: assert property ($rose(status.devLock) &&
    status.band == dvm_pkg::BAND_SLOW |-> devRun_ff >=
    P_DEV_SLOW_CYC - 36'h2) else $error("slow deviation lock early");
endmodule // dvm_velocity_monitor_assertions

bind dvm_velocity_monitor dvm_velocity_monitor_assertions #(
  .P_GATE_CYC(P_GATE_CYC), .P_DEV_SLOW_CYC(P_DEV_SLOW_CYC),
  .P_DEV_FAST_CYC(P_DEV_FAST_CYC), .P_DIR_CYC(P_DIR_CYC)
) chk_u (.clk_sys(clk_sys), .arst_n(arst_n), .encA(encA), .encB(encB),
  .cfg(cfg), .status(status));

// File: bench/dvm_enc_model.sv
`timescale 1ns/1ps
module dvm_enc_model (
  // clock
  input wire logic          clk_sys,
  // motion control
  input wire logic          run,
  input wire logic          rev,
  input wire logic [7:0]    phaseCyc,
  // quadrature pins
  output dvm_pkg::dvm_enc_t enc
);
  logic [1:0] quad = 2'h0;
  logic [7:0] cnt  = 8'h0;
  // each quadrature state held phaseCyc cycles
  always @(negedge clk_sys) begin
    if (run && cnt + 8'h1 >= phaseCyc) begin
      cnt  <= 8'h0;
      quad <= rev ? quad - 2'h1 : quad + 2'h1;
    end else if (run) begin
      cnt <= cnt + 8'h1;
    end
  end
  // gray order 00, 10, 11, 01
  assign enc = '{ch1: quad == 2'h1 || quad == 2'h2, ch2: quad[1]};
endmodule // dvm_enc_model

// File: bench/dvm_velocity_monitor_bench.sv
`timescale 1ns/1ps
module dvm_velocity_monitor_bench;
  logic               clk_sys;
  logic               arst_n;
  dvm_pkg::dvm_enc_t  encA;
  dvm_pkg::dvm_enc_t  encB;
  dvm_pkg::dvm_cfg_t  cfg;
  dvm_pkg::dvm_stat_t status;
  logic               runA, runB, revA, revB;
  logic [7:0]         phA, phB;
  logic [111:0]       notes[$];
  logic [111:0]       note;
  int                 error_cnt = 0;
  int                 checked = 0;
  event               lookEv;
  localparam logic [55:0] M_FL = {7'h7f, 49'h0};
  localparam logic [55:0] M_LK = {7'h73, 49'h0};
  localparam logic [55:0] M_V  = {7'h73, 16'h0, 33'h1ffffffff};

  dvm_velocity_monitor #(.P_GATE_CYC(36'h64), .P_DEV_SLOW_CYC(36'h7d0),
    .P_DEV_FAST_CYC(36'h258), .P_DIR_CYC(36'h32)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .encA(encA), .encB(encB),
    .cfg(cfg), .status(status));
  dvm_enc_model encA_u (.clk_sys(clk_sys), .run(runA), .rev(revA),
    .phaseCyc(phA), .enc(encA));
  dvm_enc_model encB_u (.clk_sys(clk_sys), .run(runB), .rev(revB),
    .phaseCyc(phB), .enc(encB));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic look(input logic [6:0] fl, input logic [15:0] vA,
    input logic [15:0] vB, input logic vld, input logic [55:0] m);
    notes.push_back({m, {fl, 16'h0, vA, vB, vld} & m});
    -> lookEv;
  endtask

  task automatic drv(input logic a, ra, input logic [7:0] pa,
    input logic b, rb, input logic [7:0] pb);
    runA = a;
    revA = ra;
    phA  = pa;
    runB = b;
    revB = rb;
    phB  = pb;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic rst(input logic en, input logic [15:0] ppc,
    input logic [5:0] tol);
    @(negedge clk_sys);
    arst_n = 1'b0;
    drv(1'b0, 1'b0, 8'h5, 1'b0, 1'b0, 8'h5);
    cfg = '{velEnable: en, pulsesPerCm: ppc, tolPct: tol};
    wt(4);
    arst_n = 1'b1;
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // result monitor
  initial begin
    forever begin
      @(lookEv);
      note = notes.pop_front();
      chk(56'(status) & note[111:56], note[55:0]);
    end
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    final_report;
  end

  initial begin
    arst_n = 1'b0;
    cfg = '0;
    drv(1'b0, 1'b0, 8'h5, 1'b0, 1'b0, 8'h5);
    void'($urandom(32'h85b1));
    rst(1'b1, 16'h1, 6'h2d);
    look(7'h0, 16'h0, 16'h0, 1'b0, '1);
    rst(1'b0, 16'h1, 6'h2d);
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b0, 8'h5);
    wt(400);
    look(7'h0, 16'h0, 16'h0, 1'b0, '1);
    rst(1'b1, 16'h1, 6'($urandom_range(40, 63)));
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b0, 8'h7);
    wt(400);
    look(7'h03, 16'h0, 16'h0, 1'b0, M_FL);
    wt(800);
    look(7'h03, 16'h0, 16'h0, 1'b0, M_FL);
    rst(1'b1, 16'h1, 6'($urandom_range(46, 63)));
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b0, 8'hd);
    wt(400);
    look(7'h0b, 16'h0, 16'h0, 1'b0, M_FL);
    rst(1'b1, 16'h1, 6'($urandom_range(0, 44)));
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b0, 8'h19);
    wt(400);
    look(7'h0b, 16'h0, 16'h0, 1'b0, M_FL);
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b0, 8'h5);
    wt(300);
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b0, 8'h19);
    wt(400);
    look(7'h0b, 16'h0, 16'h0, 1'b0, M_FL);
    wt(500);
    look(7'h63, 16'h0, 16'h0, 1'b0, M_LK);
    rst(1'b1, 16'h2, 6'($urandom_range(0, 44)));
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b0, 8'h19);
    wt(1200);
    look(7'h09, 16'h0, 16'h0, 1'b0, M_FL);
    wt(1500);
    look(7'h61, 16'h0, 16'h0, 1'b0, M_LK);
    rst(1'b1, 16'h8, 6'($urandom_range(0, 44)));
    drv(1'b1, 1'b0, 8'h5, 1'b0, 1'b0, 8'h5);
    wt(3000);
    look(7'h00, 16'h0, 16'h0, 1'b0, M_FL);
    rst(1'b1, 16'h1, 6'($urandom_range(0, 45)));
    drv(1'b1, 1'b0, 8'h5, 1'b1, 1'b1, 8'h5);
    wt(400);
    look(7'h53, 16'h5, 16'hfffb, 1'b1, M_V);
    wt(2);
    final_report;
  end
endmodule // dvm_velocity_monitor_bench
